// >>> core/edpc_core.sv
/*
 * Energy-detect power control: counts line data and error events,
 * moves the line driver between powered-up and powered-down states,
 * sends energy pulses on power-up and exposes one 16-bit register.
 * Assumes event and energy inputs come from the analog line side,
 * asynchronous to sys_clk, and a simple register port on sys_clk.
 */
`timescale 1ns/1ns
module edpc_core #(
  parameter int IDLE_CYCLES = edpc_pkg::EDPC_IDLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic data_event_in,
  input wire logic error_event_in,
  input wire logic line_energy_in,
  output logic line_driver_on,
  output logic energy_pulse,
  output logic energy_power_state
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [2:0] data_s;          // Sync chain and edge history, data
    logic [2:0] err_s;           // Sync chain and edge history, error
    logic [1:0] energy_s;        // Sync chain, energy level
    logic energy_sense_enable;   // Mode enable
    logic auto_wake_on_energy;   // Automatic power-up
    logic auto_sleep_on_silence; // Automatic power-down
    logic manual_power_toggle;   // Self-clearing toggle request
    logic pulse_burst_disable;   // One pulse instead of a burst
    edpc_pkg::edpc_pwr_e pwr;    // Current power state
    logic error_threshold_hit;   // Sticky, clear on read
    logic data_threshold_hit;    // Sticky, clear on read
    logic [3:0] error_event_threshold;
    logic [3:0] data_event_threshold;
    logic [3:0] err_cnt;         // Saturating error event count
    logic [3:0] data_cnt;        // Saturating data event count
    logic [2:0] pulses_left;     // Pulses still to send
    logic pulse;                 // Pulse output
    logic drv_on;                // Line driver power output
    logic [15:0] rdata;          // Read data register
  } edpc_core_s;

  edpc_core_s st_reg;
  edpc_core_s st_next;

  // ****************************************************************
  // Idle timer
  // ****************************************************************
  logic data_rise; // Synchronised data event
  logic err_rise;  // Synchronised error event
  logic idle_expired;

  edpc_idle_timer #(
    .IDLE_CYCLES(IDLE_CYCLES)
  ) u_idle_timer (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .restart(data_rise),
    .expired(idle_expired)
  );

  // Edges are taken from the second stage on, never the first flop
  assign data_rise = st_reg.data_s[1] & ~st_reg.data_s[2];
  assign err_rise = st_reg.err_s[1] & ~st_reg.err_s[2];

  // Register image as software sees it
  function automatic logic [15:0] edpc_image(input edpc_core_s s);
    logic [15:0] v;
    v = 16'h0000;
    v[edpc_pkg::EDPC_BIT_ENABLE] = s.energy_sense_enable;
    v[edpc_pkg::EDPC_BIT_AUTO_WAKE] = s.auto_wake_on_energy;
    v[edpc_pkg::EDPC_BIT_AUTO_SLEEP] = s.auto_sleep_on_silence;
    v[edpc_pkg::EDPC_BIT_MANUAL] = s.manual_power_toggle;
    v[edpc_pkg::EDPC_BIT_BURST_DIS] = s.pulse_burst_disable;
    v[edpc_pkg::EDPC_BIT_PWR_STATE] = (s.pwr == edpc_pkg::EDPC_PWR_UP);
    v[edpc_pkg::EDPC_BIT_ERR_HIT] = s.error_threshold_hit;
    v[edpc_pkg::EDPC_BIT_DATA_HIT] = s.data_threshold_hit;
    v[edpc_pkg::EDPC_ERR_THR_LSB +: 4] = s.error_event_threshold;
    v[edpc_pkg::EDPC_DATA_THR_LSB +: 4] = s.data_event_threshold;
    return v;
  endfunction

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  logic hit_reg;       // This access addresses the control register
  logic data_reached;  // Data threshold met this cycle
  logic err_reached;   // Error threshold met this cycle
  logic go_up;
  logic go_down;

  always_comb begin
    st_next = st_reg;
    hit_reg = (reg_addr == edpc_pkg::EDPC_CTRL_ADDR);
    data_reached = 1'b0;
    err_reached = 1'b0;
    go_up = 1'b0;
    go_down = 1'b0;

    // Two flops before any logic looks at a line input
    st_next.data_s = {st_reg.data_s[1:0], data_event_in};
    st_next.err_s = {st_reg.err_s[1:0], error_event_in};
    st_next.energy_s = {st_reg.energy_s[0], line_energy_in};

    // Read data and clear-on-read; a later set below still wins
    if (reg_rd) begin
      if (hit_reg) begin
        st_next.rdata = edpc_image(st_reg);
        // [RULE9] Error flag read-clear
        st_next.error_threshold_hit = 1'b0;
        // [RULE10] Data flag read-clear
        st_next.data_threshold_hit = 1'b0;
      end else begin
        // Unmapped offsets read as zero
        st_next.rdata = 16'h0000;
      end
    end

    // Manual toggle served one cycle after it is written, then cleared
    // [RULE5] Manual state change
    if (st_reg.manual_power_toggle) begin
      st_next.manual_power_toggle = 1'b0;
      if (st_reg.energy_sense_enable) begin
        go_up = (st_reg.pwr == edpc_pkg::EDPC_PWR_DOWN);
        go_down = (st_reg.pwr == edpc_pkg::EDPC_PWR_UP);
      end
    end

    // Register write; status bits are not writable
    if (reg_wr && hit_reg) begin
      st_next.energy_sense_enable = reg_wdata[edpc_pkg::EDPC_BIT_ENABLE];
      st_next.auto_wake_on_energy = reg_wdata[edpc_pkg::EDPC_BIT_AUTO_WAKE];
      st_next.auto_sleep_on_silence = reg_wdata[edpc_pkg::EDPC_BIT_AUTO_SLEEP];
      st_next.manual_power_toggle = reg_wdata[edpc_pkg::EDPC_BIT_MANUAL];
      st_next.pulse_burst_disable = reg_wdata[edpc_pkg::EDPC_BIT_BURST_DIS];
      // [RULE11] Error threshold field
      st_next.error_event_threshold = reg_wdata[edpc_pkg::EDPC_ERR_THR_LSB +: 4];
      // [RULE12] Data threshold field
      st_next.data_event_threshold = reg_wdata[edpc_pkg::EDPC_DATA_THR_LSB +: 4];
    end

    // Event counters saturate so a long burst never wraps below threshold
    if (data_rise) begin
      if (st_reg.data_cnt != 4'hF) begin
        st_next.data_cnt = st_reg.data_cnt + 4'h1;
      end
      data_reached = (st_next.data_cnt >= st_reg.data_event_threshold);
    end
    if (err_rise) begin
      if (st_reg.err_cnt != 4'hF) begin
        st_next.err_cnt = st_reg.err_cnt + 4'h1;
      end
      err_reached = (st_next.err_cnt >= st_reg.error_event_threshold);
    end

    // [RULE11] Error counter idle reset
    // [RULE12] Data counter idle reset
    if (idle_expired) begin
      st_next.err_cnt = 4'h0;
      st_next.data_cnt = 4'h0;
    end

    // Flags set over a same-cycle read clear
    // [RULE9] Error flag set, no action
    if (err_reached && st_reg.energy_sense_enable) begin
      st_next.error_threshold_hit = 1'b1;
    end
    // [RULE10] Data flag set
    if (data_reached && st_reg.energy_sense_enable) begin
      st_next.data_threshold_hit = 1'b1;
    end

    // Automatic moves, only when no manual move is pending
    if (!go_up && !go_down && st_reg.energy_sense_enable) begin
      // [RULE3] Auto wake on data
      if (st_reg.auto_wake_on_energy && data_reached && st_reg.pwr == edpc_pkg::EDPC_PWR_DOWN) begin
        go_up = 1'b1;
      end
      // [RULE4] Auto sleep on silence
      if (st_reg.auto_sleep_on_silence && !st_reg.energy_s[1] && st_reg.pwr == edpc_pkg::EDPC_PWR_UP) begin
        go_down = 1'b1;
      end
    end

    // [RULE1] Mode gated by enable
    if (!st_reg.energy_sense_enable) begin
      // Mode off: driver stays powered, counts restart when re-enabled
      st_next.pwr = edpc_pkg::EDPC_PWR_UP;
      st_next.err_cnt = 4'h0;
      st_next.data_cnt = 4'h0;
    end else if (go_up) begin
      // [RULE7] Start pulse burst
      st_next.pwr = edpc_pkg::EDPC_PWR_UP;
      st_next.pulses_left = st_reg.pulse_burst_disable ? edpc_pkg::EDPC_BURST_SINGLE
                                                       : edpc_pkg::EDPC_BURST_FULL;
      st_next.data_cnt = 4'h0;
    end else if (go_down) begin
      st_next.pwr = edpc_pkg::EDPC_PWR_DOWN;
      st_next.pulses_left = 3'h0;
    end

    // One-cycle pulses separated by one low cycle
    // [RULE7] Pulse sequencing
    st_next.pulse = 1'b0;
    // A power-down cuts a burst short so no pulse leaves a dead driver
    if (!go_up && !go_down && st_reg.pulses_left != 3'h0 && !st_reg.pulse) begin
      st_next.pulse = 1'b1;
      st_next.pulses_left = st_reg.pulses_left - 3'h1;
    end

    // Driver powered while mode is off or state is up
    st_next.drv_on = !st_next.energy_sense_enable || (st_next.pwr == edpc_pkg::EDPC_PWR_UP);
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // Reset leaves the mode off with the driver powered; the state bit reads one from the first cycle after
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      st_reg <= '0;
      st_reg.auto_wake_on_energy <= edpc_pkg::EDPC_RST_AUTO_WAKE;
      st_reg.auto_sleep_on_silence <= edpc_pkg::EDPC_RST_AUTO_SLEEP;
      st_reg.energy_sense_enable <= edpc_pkg::EDPC_RST_ENABLE;
      st_reg.pulse_burst_disable <= edpc_pkg::EDPC_RST_BURST_DIS;
      st_reg.error_event_threshold <= edpc_pkg::EDPC_RST_ERR_THR;
      st_reg.data_event_threshold <= edpc_pkg::EDPC_RST_DATA_THR;
      st_reg.pwr <= edpc_pkg::EDPC_PWR_DOWN;
      st_reg.drv_on <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs, all straight from flops
  // ****************************************************************
  assign reg_rdata = st_reg.rdata;
  assign line_driver_on = st_reg.drv_on;
  assign energy_pulse = st_reg.pulse;
  // [RULE8] Power state view
  assign energy_power_state = (st_reg.pwr == edpc_pkg::EDPC_PWR_UP);

endmodule

// >>> core/edpc_pkg.sv
/*
 * Constants for the energy-detect power control block: register offset,
 * field positions, reset values, burst counts and the idle timeout.
 * Assumes a 10 MHz main clock and a single synchronous active-low reset.
 */
// What this block does
// [RULE1] Power management runs only with enable set
// [RULE2] Software disables crossover when enabling without negotiation
// [RULE3] Auto wake on reaching data threshold
// [RULE4] Auto sleep when line energy disappears
// [RULE5] Manual toggle flips state, then self-clears
// [RULE6] Software clears interrupt before manual toggle
// [RULE7] Power-up sends four pulses, one if disabled
// [RULE8] State bit reads one when powered up
// [RULE9] Error threshold flag sticky, clear on read
// [RULE10] Data threshold flag sticky, clear on read
// [RULE11] Error threshold field, counter idle reset
// [RULE12] Data threshold field, counter idle reset
// [RULE13] Idle timeout from restartable counter of sys_clk cycles
package edpc_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [4:0] EDPC_CTRL_ADDR = 5'h1D; // Energy detect control offset

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int EDPC_BIT_ENABLE = 15;       // energy_sense_enable
  localparam int EDPC_BIT_AUTO_WAKE = 14;    // auto_wake_on_energy
  localparam int EDPC_BIT_AUTO_SLEEP = 13;   // auto_sleep_on_silence
  localparam int EDPC_BIT_MANUAL = 12;       // manual_power_toggle
  localparam int EDPC_BIT_BURST_DIS = 11;    // pulse_burst_disable
  localparam int EDPC_BIT_PWR_STATE = 10;    // energy_power_state
  localparam int EDPC_BIT_ERR_HIT = 9;       // error_threshold_hit
  localparam int EDPC_BIT_DATA_HIT = 8;      // data_threshold_hit
  localparam int EDPC_ERR_THR_LSB = 4;       // error_event_threshold low bit
  localparam int EDPC_DATA_THR_LSB = 0;      // data_event_threshold low bit

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic EDPC_RST_ENABLE = 1'h0;
  localparam logic EDPC_RST_AUTO_WAKE = 1'h1;
  localparam logic EDPC_RST_AUTO_SLEEP = 1'h1;
  localparam logic EDPC_RST_BURST_DIS = 1'h0;
  localparam logic [3:0] EDPC_RST_ERR_THR = 4'h1;
  localparam logic [3:0] EDPC_RST_DATA_THR = 4'h1;

  // ****************************************************************
  // Pulse burst and timing
  // ****************************************************************
  localparam logic [2:0] EDPC_BURST_FULL = 3'h4;   // Pulses per power-up
  localparam logic [2:0] EDPC_BURST_SINGLE = 3'h1; // Pulses when bursting is off
  localparam int EDPC_CLK_HZ = 10000000;           // Main clock rate
  localparam int EDPC_IDLE_TIME_MS = 2000;         // Idle time before counters reset
  localparam int EDPC_IDLE_CYCLES = EDPC_IDLE_TIME_MS * (EDPC_CLK_HZ / 1000);

  // Power state of the energy detect machine
  typedef enum logic {
    EDPC_PWR_DOWN = 1'b0,
    EDPC_PWR_UP = 1'b1
  } edpc_pwr_e;

endpackage

// >>> core/edpc_idle_timer.sv
/*
 * Restartable idle timer: pulses once when no restart has been seen
 * for IDLE_CYCLES clocks, then starts a new period.
 * Assumes restart is already in the sys_clk domain.
 */
`timescale 1ns/1ns
module edpc_idle_timer #(
  parameter int IDLE_CYCLES = edpc_pkg::EDPC_IDLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic restart,
  output logic expired
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [31:0] count; // Cycles since last restart
    logic expired;      // One-cycle timeout pulse
  } edpc_tmr_s;

  edpc_tmr_s tmr_reg;
  edpc_tmr_s tmr_next;

  // Next state: restart wins so a late event never lets the timer fire
  // [RULE13] Idle count in sys_clk cycles, no prescaler
  always_comb begin
    tmr_next = tmr_reg;
    tmr_next.expired = 1'b0;
    if (restart) begin
      tmr_next.count = 32'h0;
    end else if (tmr_reg.count >= 32'(IDLE_CYCLES - 1)) begin
      // Period over, flag and start again
      tmr_next.count = 32'h0;
      tmr_next.expired = 1'b1;
    end else begin
      tmr_next.count = tmr_reg.count + 32'h1;
    end
  end

  // Register update
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign expired = tmr_reg.expired;

endmodule

// >>> verification/edpc_monitor.sv
/* Port checker for edpc_core.
   Assumes it is bound onto edpc_core; sees only its ports. */
`timescale 1ns/1ns
module edpc_monitor #(
  parameter int IDLE_CYCLES = 50
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic line_driver_on,
  input wire logic energy_pulse,
  input wire logic energy_power_state
);
  // ************************************
  // Helper state
  // ************************************
  logic en_q; // Shadow of the enable bit
  logic drv_q; // Driver level one cycle ago
  logic [3:0] burst_cnt; // Pulses since last power-up
  // Shadow enable and count pulses per power-up
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      en_q <= 1'b0;
      drv_q <= 1'b1;
      burst_cnt <= 4'h0;
    end else begin
      drv_q <= line_driver_on;
      if (reg_wr && reg_addr == edpc_pkg::EDPC_CTRL_ADDR) begin
        en_q <= reg_wdata[15];
      end
      if (line_driver_on && !drv_q) begin
        burst_cnt <= 4'h0;
      end else if (energy_pulse) begin
        burst_cnt <= burst_cnt + 4'h1;
      end
    end
  end
  // ************************************
  // Assertions
  // ************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence ctrl_wr;
    reg_wr && reg_addr == edpc_pkg::EDPC_CTRL_ADDR;
  endsequence
  sequence man_req;
    ctrl_wr ##0 (reg_wdata[15] && reg_wdata[12] && en_q);
  endsequence
  a_state_mirror: assert property (reg_rd && reg_addr == edpc_pkg::EDPC_CTRL_ADDR
    |=> reg_rdata[10] == $past(energy_power_state)) else $error("state bit differs");
  a_unmapped_zero: assert property (reg_rd && reg_addr != edpc_pkg::EDPC_CTRL_ADDR
    |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved");
  a_pulse_gap: assert property (energy_pulse |=> !energy_pulse) else $error("pulse too long");
  a_driver_follow: assert property ($rose(energy_power_state) |=> line_driver_on)
    else $error("driver not on");
  a_burst_start: assert property ($rose(line_driver_on) && en_q |=> energy_pulse)
    else $error("no pulse after power-up");
  a_burst_max: assert property (burst_cnt <= 4'h4) else $error("too many pulses");
  a_manual_flip: assert property (man_req |-> ##2 energy_power_state != $past(energy_power_state, 2))
    else $error("manual toggle ignored");
  a_off_driver: assert property (!en_q [*4] |-> line_driver_on)
    else $error("driver off while disabled");
endmodule

bind edpc_core edpc_monitor #(.IDLE_CYCLES(IDLE_CYCLES)) u_edpc_monitor (.sys_clk(sys_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .line_driver_on(line_driver_on), .energy_pulse(energy_pulse), .energy_power_state(energy_power_state));

// >>> verification/edpc_line_model.sv
/* Line-side model: data and error strokes and the energy level.
   Assumes its tasks are called from the bench on sys_clk. */
`timescale 1ns/1ns
module edpc_line_model (
  input wire logic sys_clk,
  output logic data_event_in,
  output logic error_event_in,
  output logic line_energy_in
);
  // Quiet line at time zero
  initial begin
    data_event_in = 1'b0;
    error_event_in = 1'b0;
    line_energy_in = 1'b0;
  end
  // Strokes are 3 high and 3 low, past the 2-cycle minimum
  task automatic stroke(input bit err, input int n);
    repeat (n) begin
      @(posedge sys_clk);
      line_energy_in <= 1'b1;
      if (err) error_event_in <= 1'b1;
      else data_event_in <= 1'b1;
      repeat (3) @(posedge sys_clk);
      error_event_in <= 1'b0;
      data_event_in <= 1'b0;
      repeat (2) @(posedge sys_clk);
    end
  endtask
  // Energy leaves the line
  task automatic quiet;
    @(posedge sys_clk);
    line_energy_in <= 1'b0;
  endtask
endmodule

// >>> verification/test_energy_detect_power_control.sv
/* Self-checking bench for edpc_core driven through its register port.
   Assumes the monitor binds itself and the line model drives events. */
`timescale 1ns/1ns
module test_energy_detect_power_control;
  localparam logic [4:0] ctl_a = edpc_pkg::EDPC_CTRL_ADDR; // Control offset
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [4:0] reg_addr = 5'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic data_event_in, error_event_in, line_energy_in;
  logic line_driver_on, energy_pulse, energy_power_state;
  logic [15:0] pulses = 16'h0000; // Pulses seen since last clear
  int fail_count = 0;
  int n_checks = 0;
  // 100 ns clock
  always #50 sys_clk = ~sys_clk;
  // Count energy pulses
  always @(posedge sys_clk) if (energy_pulse === 1'b1) pulses <= pulses + 16'h0001;
  // Short idle timeout keeps the run brief
  edpc_core #(.IDLE_CYCLES(50)) u_edpc_core (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .data_event_in(data_event_in), .error_event_in(error_event_in), .line_energy_in(line_energy_in),
    .line_driver_on(line_driver_on), .energy_pulse(energy_pulse), .energy_power_state(energy_power_state));
  edpc_line_model u_edpc_line_model (.sys_clk(sys_clk), .data_event_in(data_event_in),
    .error_event_in(error_event_in), .line_energy_in(line_energy_in));
  // ************************************
  // Tasks
  // ************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // Masked read compare; data is settled one cycle after the read edge
  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input logic [15:0] m);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk(reg_rdata & m, exp & m, "read");
  endtask
  // Bounded wait for a power state
  task automatic wait_state(input logic v);
    // Step off the edge so a state launched there is settled first
    #1;
    for (int i = 0; i < 60 && energy_power_state !== v; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk({15'h0000, energy_power_state}, {15'h0000, v}, "state wait");
    if (energy_power_state !== v) tally_and_finish();
  endtask
  task automatic burst(input logic [15:0] n);
    repeat (12) @(posedge sys_clk);
    chk(pulses, n, "pulse count");
  endtask
  // ************************************
  // Main sequence
  // ************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    rstn <= 1'b1;
    rd_chk(ctl_a, 16'h6011, 16'hFBFF);
    rd_chk(5'h05, 16'h0000, 16'hFFFF);
    wr(5'h05, 16'hFFFF);
    rd_chk(ctl_a, 16'h6011, 16'hFBFF);
    $display("test reset done");
    // No negotiation logic sits here, so enabling needs no crossover write first
    wr(ctl_a, 16'hE711);
    wait_state(1'b0);
    rd_chk(ctl_a, 16'hE011, 16'hFFFF);
    chk({15'h0000, line_driver_on}, 16'h0000, "driver");
    pulses = 16'h0000;
    u_edpc_line_model.stroke(1'b0, 1);
    wait_state(1'b1);
    burst(16'h0004);
    rd_chk(ctl_a, 16'hE511, 16'hFFFF);
    rd_chk(ctl_a, 16'hE411, 16'hFFFF);
    u_edpc_line_model.quiet();
    wait_state(1'b0);
    $display("test wake sleep done");
    wr(ctl_a, 16'hE811);
    pulses = 16'h0000;
    u_edpc_line_model.stroke(1'b0, 1);
    wait_state(1'b1);
    burst(16'h0001);
    u_edpc_line_model.quiet();
    wait_state(1'b0);
    rd_chk(ctl_a, 16'hE911, 16'hFFFF);
    $display("test single pulse done");
    // Wake off: a data event sets the data flag and restarts the idle timer at a known edge, no wake
    wr(ctl_a, 16'hA021);
    u_edpc_line_model.stroke(1'b1, 1);
    repeat (70) @(posedge sys_clk);
    u_edpc_line_model.stroke(1'b0, 1);
    u_edpc_line_model.stroke(1'b1, 1);
    rd_chk(ctl_a, 16'hA121, 16'hFFFF);
    u_edpc_line_model.stroke(1'b1, 1);
    rd_chk(ctl_a, 16'hA221, 16'hFFFF);
    $display("test error threshold done");
    // Let the idle timer drop the data count left by the error test
    repeat (60) @(posedge sys_clk);
    wr(ctl_a, 16'hE013);
    u_edpc_line_model.stroke(1'b0, 2);
    rd_chk(ctl_a, 16'hE013, 16'hFFFF);
    u_edpc_line_model.stroke(1'b0, 1);
    wait_state(1'b1);
    rd_chk(ctl_a, 16'hE513, 16'hFFFF);
    $display("test data threshold done");
    wr(ctl_a, 16'h8013);
    wr(ctl_a, 16'h9013);
    wait_state(1'b0);
    rd_chk(ctl_a, 16'h8013, 16'hFFFF);
    pulses = 16'h0000;
    wr(ctl_a, 16'h9013);
    wait_state(1'b1);
    burst(16'h0004);
    rd_chk(ctl_a, 16'h8413, 16'hFFFF);
    $display("test manual done");
    tally_and_finish();
  end
endmodule
